// >>> rtl/dram_ctl_pkg.sv
// package: constants and carrier types for the dram control register pair
// Operation
// - remap smm overlay onto A0000h and B0000h
// - two 3-bit legacy dram configuration fields
// - bit 3 enables byte lane 2 parity
// - strap low selects shared pin function
// - read field selects 3-2-2-2, 4-3-3-3, 5-4-4-4
// - write bit selects 4-3-3-3 or 3-x-x-x
// - rising flush bit pulses flush one clock
// - flush bit never self-clears
// - bit 2 suppresses direction strobe on ports
// - isa clock divides input by 6/5/4/3
// - divide-by-6 may delay address strobe one clock
package dram_ctl_pkg;

    // ----------------------------------------
    // register indices and bus layout
    // ----------------------------------------
    localparam int          BUS_ADDR_W    = 8;       // byte address width
    localparam int          BUS_DATA_W    = 32;      // wishbone data width
    localparam logic [5:0]  IDX_DRAM_ONE  = 6'h24;   // first register index
    localparam logic [5:0]  IDX_DRAM_TWO  = 6'h25;   // second register index
    localparam logic [1:0]  WORD_LSBS     = 2'h0;    // byte address = index * 4

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [7:0]  ONE_RESET     = 8'h08;   // parity on, config 000
    localparam logic [7:0]  TWO_RESET     = 8'h70;   // read 11, write 1

    // ----------------------------------------
    // field positions, first register
    // ----------------------------------------
    localparam int          ONE_REMAP_BIT = 7;       // smm remap
    localparam int          ONE_CFGH_LSB  = 4;       // config field 6:4
    localparam int          ONE_PAR_BIT   = 3;       // lane 2 parity
    localparam int          ONE_CFGL_LSB  = 0;       // config field 2:0
    localparam int          CFG_W         = 3;       // config field width

    // ----------------------------------------
    // field positions, second register
    // ----------------------------------------
    localparam int          TWO_PIN_BIT   = 7;       // shared pin select
    localparam int          TWO_RD_LSB    = 5;       // read timing 6:5
    localparam int          TWO_WR_BIT    = 4;       // write timing
    localparam int          TWO_FLUSH_BIT = 3;       // flush trigger
    localparam int          TWO_TRANSCEIVER_DIRECTION_N_BIT  = 2;       // strobe suppress
    localparam int          TWO_ISA_LSB   = 0;       // isa clock 1:0

    // ----------------------------------------
    // read timing codes and isa clock codes
    // ----------------------------------------
    localparam logic [1:0]  RD_FAST       = 2'h0;    // 3-2-2-2
    localparam logic [1:0]  RD_MID        = 2'h2;    // 4-3-3-3
    localparam logic [1:0]  ISA_DIV6      = 2'h0;    // input / 6
    localparam logic [1:0]  ISA_DIV5      = 2'h1;    // input / 5
    localparam logic [1:0]  ISA_DIV4      = 2'h2;    // input / 4
    localparam logic [2:0]  DIV_BY6       = 3'h6;
    localparam logic [2:0]  DIV_BY5       = 3'h5;
    localparam logic [2:0]  DIV_BY4       = 3'h4;
    localparam logic [2:0]  DIV_BY3       = 3'h3;

    // ----------------------------------------
    // burst profile clock counts
    // ----------------------------------------
    localparam logic [2:0]  CLK_2         = 3'h2;
    localparam logic [2:0]  CLK_3         = 3'h3;
    localparam logic [2:0]  CLK_4         = 3'h4;
    localparam logic [2:0]  CLK_5         = 3'h5;

    // ----------------------------------------
    // address decode constants
    // ----------------------------------------
    localparam logic [3:0]  SEG_A         = 4'hA;    // A0000h segment
    localparam logic [3:0]  SEG_B         = 4'hB;    // B0000h segment
    localparam logic [15:0] PORT_KBD_DATA = 16'h0060;
    localparam logic [15:0] PORT_KBD_CMD  = 16'h0064;
    localparam logic [15:0] PORT_RTC_IDX  = 16'h0070;
    localparam logic [15:0] PORT_RTC_DATA = 16'h0071;

    // burst profile: lead-off then each following beat
    typedef struct packed {
        logic [2:0] lead;   // first access clocks
        logic [2:0] burst;  // later beat clocks
    } dram_timing_t;

    // bus slave states, one-hot
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,   // waiting for strobe
        BUS_ACK  = 2'b10    // ack given this cycle
    } bus_state_t;

endpackage : dram_ctl_pkg

// >>> rtl/isa_clock_divider.sv
// module: programmable divider making the isa bus clock and its tick
`timescale 1ns/1ps
`default_nettype none
module isa_clock_divider #(
    parameter int CNT_W = 3                  // counter width
) (
    input  wire logic             sys_clk,   // cpu clock
    input  wire logic             reset,     // async, active high
    input  wire logic [CNT_W-1:0] divisor,   // divide ratio, 3 to 6
    output var  logic             tick,      // one-cycle enable per period
    output var  logic             clk_level  // divided clock level
);

    // ----------------------------------------
    // counter
    // ----------------------------------------
    logic [CNT_W-1:0] count_q;               // position in period
    logic [CNT_W-1:0] count_d;
    wire              last_w = (count_q >= divisor - CNT_W'(1)); // end of period
    wire  [CNT_W-1:0] half_w = divisor >> 1; // high phase length

    assign count_d = last_w ? '0 : count_q + CNT_W'(1);

    // count and shape the output level
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            count_q   <= '0;
            tick      <= 1'b0;
            clk_level <= 1'b0;
        end
        else
        begin
            count_q   <= count_d;
            tick      <= last_w;
            clk_level <= (count_d < half_w);
        end
    end

endmodule : isa_clock_divider
`default_nettype wire

// >>> rtl/dram_control_regs.sv
// module: dram control register pair with wishbone slave and pin logic
//
// Our own choice: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module dram_control_regs (
    input  wire logic        sys_clk,                  // cpu clock
    input  wire logic        reset,                    // async, active high
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output var  logic [31:0] wb_dat_o,
    output var  logic        wb_ack_o,
    // strap and configuration from elsewhere
    input  wire logic        pin_function_strap,       // level caught after reset
    input  wire logic        cache_module_enable,      // cache module support on
    input  wire logic        write_burst_fast,         // 3-2-2-2 writes when set and write bit clear
    input  wire logic        strobe_delay_enable,      // allow strobe delay
    // cpu cycle view
    input  wire logic [31:0] cpu_addr,                 // memory address
    input  wire logic        io_cycle,                 // io access in progress
    input  wire logic [15:0] io_port,                  // io port address
    input  wire logic        address_strobe_in_n,      // raw address strobe
    input  wire logic        memory_data_direction_n,  // from sequencer
    input  wire logic        local_memory_indicate_n,  // from sequencer
    input  wire logic        transceiver_request_n,    // raw direction strobe
    // outputs
    output var  logic        smm_remap_enable,
    output var  logic        smm_remap_hit,
    output var  logic [2:0]  dram_config_high,
    output var  logic [2:0]  dram_config_low,
    output var  logic        parity_lane2_enable,
    output var  logic        shared_pin_n,
    output var  logic [5:0]  read_timing,              // dram_timing_t
    output var  logic [5:0]  write_timing,             // dram_timing_t
    output var  logic        cache_flush_out_n,
    output var  logic        transceiver_direction_n,
    output var  logic        address_strobe_n,
    output var  logic        isa_bus_clock,
    output var  logic        isa_clock_tick
);

    // ----------------------------------------
    // register state
    // ----------------------------------------
    logic [7:0]                   one_q;        // first register
    logic [7:0]                   two_q;        // second register
    logic [7:0]                   one_d;
    logic [7:0]                   two_d;
    dram_ctl_pkg::bus_state_t     state_q;      // slave state
    dram_ctl_pkg::bus_state_t     state_d;
    logic                         strap_q;      // caught strap level
    logic                         strap_done_q; // strap taken
    logic                         strobe_d1_q;  // strobe one clock late

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    wire       req_w     = wb_cyc_i & wb_stb_i;                 // live request
    wire       take_w    = req_w & (state_q == dram_ctl_pkg::BUS_IDLE);
    wire [7:0] one_adr_w = {dram_ctl_pkg::IDX_DRAM_ONE, dram_ctl_pkg::WORD_LSBS};
    wire [7:0] two_adr_w = {dram_ctl_pkg::IDX_DRAM_TWO, dram_ctl_pkg::WORD_LSBS};
    wire       hit_one_w = (wb_adr_i == one_adr_w);            // first register
    wire       hit_two_w = (wb_adr_i == two_adr_w);            // second register
    wire       wr_lane_w = take_w & wb_we_i & wb_sel_i[0];      // low byte write
    wire       wr_one_w  = wr_lane_w & hit_one_w;
    wire       wr_two_w  = wr_lane_w & hit_two_w;
    wire [7:0] wdat_w    = wb_dat_i[7:0];

    // read select: unmapped reads as zero
    wire [7:0] rsel_w    = hit_one_w ? one_q :
                           hit_two_w ? two_q : 8'h00;

    // next register values
    assign one_d = wr_one_w ? wdat_w : one_q;
    assign two_d = wr_two_w ? wdat_w : two_q;

    // ----------------------------------------
    // bus slave state machine
    // ----------------------------------------
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            dram_ctl_pkg::BUS_IDLE:
            begin
                if (req_w)
                    state_d = dram_ctl_pkg::BUS_ACK;            // answer next edge
            end
            dram_ctl_pkg::BUS_ACK:
            begin
                state_d = dram_ctl_pkg::BUS_IDLE;               // ack one cycle
            end
            default:
            begin
                state_d = dram_ctl_pkg::BUS_IDLE;
            end
        endcase
    end

    // bus state, ack and read data
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            state_q  <= dram_ctl_pkg::BUS_IDLE;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            state_q  <= state_d;
            wb_ack_o <= take_w;
            if (take_w)
                wb_dat_o <= {24'h00_0000, rsel_w};
        end
    end

    // ----------------------------------------
    // register storage
    // ----------------------------------------
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            one_q <= dram_ctl_pkg::ONE_RESET;
            two_q <= dram_ctl_pkg::TWO_RESET;
        end
        else
        begin
            one_q <= one_d;
            two_q <= two_d;                                      // flush bit kept
        end
    end

    // ----------------------------------------
    // strap capture after reset release
    // ----------------------------------------
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            strap_q      <= 1'b1;
            strap_done_q <= 1'b0;
        end
        else if (!strap_done_q)
        begin
            strap_q      <= pin_function_strap;
            strap_done_q <= 1'b1;
        end
    end

    // ----------------------------------------
    // field decode: first register
    // ----------------------------------------
    wire       remap_w  = one_q[dram_ctl_pkg::ONE_REMAP_BIT];
    wire       seg_ab_w = (cpu_addr[31:20] == 12'h000) &&
                          ((cpu_addr[19:16] == dram_ctl_pkg::SEG_A) ||
                           (cpu_addr[19:16] == dram_ctl_pkg::SEG_B));
    wire [2:0] cfgh_w   = one_q[dram_ctl_pkg::ONE_CFGH_LSB +: dram_ctl_pkg::CFG_W];
    wire [2:0] cfgl_w   = one_q[dram_ctl_pkg::ONE_CFGL_LSB +: dram_ctl_pkg::CFG_W];

    // ----------------------------------------
    // field decode: second register
    // ----------------------------------------
    wire       pin_sel_w = two_q[dram_ctl_pkg::TWO_PIN_BIT];
    wire [1:0] rd_code_w = two_q[dram_ctl_pkg::TWO_RD_LSB +: 2];
    wire       wr_slow_w = two_q[dram_ctl_pkg::TWO_WR_BIT];
    wire       transceiver_direction_n_off_w = two_q[dram_ctl_pkg::TWO_TRANSCEIVER_DIRECTION_N_BIT];
    wire [1:0] isa_code_w = two_q[dram_ctl_pkg::TWO_ISA_LSB +: 2];

    // flush on a write that raises the trigger bit
    wire       flush_rise_w = wr_two_w & cache_module_enable &
                              ~two_q[dram_ctl_pkg::TWO_FLUSH_BIT] &
                              wdat_w[dram_ctl_pkg::TWO_FLUSH_BIT];

    // read burst profile; code 01 treated as slowest
    dram_ctl_pkg::dram_timing_t rd_prof_w;
    assign rd_prof_w =
        (rd_code_w == dram_ctl_pkg::RD_FAST) ?
            {dram_ctl_pkg::CLK_3, dram_ctl_pkg::CLK_2} :
        (rd_code_w == dram_ctl_pkg::RD_MID) ?
            {dram_ctl_pkg::CLK_4, dram_ctl_pkg::CLK_3} :
            {dram_ctl_pkg::CLK_5, dram_ctl_pkg::CLK_4};

    // write burst profile, lead-off clocks in the upper half
    dram_ctl_pkg::dram_timing_t wr_prof_w;
    assign wr_prof_w =
        wr_slow_w ?
            {dram_ctl_pkg::CLK_4, dram_ctl_pkg::CLK_3} :
        write_burst_fast ?
            {dram_ctl_pkg::CLK_3, dram_ctl_pkg::CLK_2} :
            {dram_ctl_pkg::CLK_3, dram_ctl_pkg::CLK_3};

    // ports whose direction strobe may be held off
    wire port_hit_w = (io_port == dram_ctl_pkg::PORT_KBD_DATA) ||
                      (io_port == dram_ctl_pkg::PORT_KBD_CMD)  ||
                      (io_port == dram_ctl_pkg::PORT_RTC_IDX)  ||
                      (io_port == dram_ctl_pkg::PORT_RTC_DATA);
    wire transceiver_direction_n_mask_w = transceiver_direction_n_off_w & io_cycle & port_hit_w;

    // shared pin follows strap and select bit
    wire pin_w = (!strap_q && pin_sel_w) ? local_memory_indicate_n
                                         : memory_data_direction_n;

    // isa divisor from code
    wire [2:0] divisor_w = (isa_code_w == dram_ctl_pkg::ISA_DIV6) ? dram_ctl_pkg::DIV_BY6 :
                           (isa_code_w == dram_ctl_pkg::ISA_DIV5) ? dram_ctl_pkg::DIV_BY5 :
                           (isa_code_w == dram_ctl_pkg::ISA_DIV4) ? dram_ctl_pkg::DIV_BY4 :
                                                                    dram_ctl_pkg::DIV_BY3;

    // strobe delay only at divide by six
    wire strobe_late_w = strobe_delay_enable &&
                         (isa_code_w == dram_ctl_pkg::ISA_DIV6);

    // ----------------------------------------
    // registered functional outputs
    // ----------------------------------------
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            smm_remap_enable        <= 1'b0;
            smm_remap_hit           <= 1'b0;
            dram_config_high        <= 3'h0;
            dram_config_low         <= 3'h0;
            parity_lane2_enable     <= 1'b1;
            shared_pin_n            <= 1'b1;
            read_timing             <= {dram_ctl_pkg::CLK_5, dram_ctl_pkg::CLK_4}; // 5-4
            write_timing            <= {dram_ctl_pkg::CLK_4, dram_ctl_pkg::CLK_3}; // 4-3
            cache_flush_out_n       <= 1'b1;
            transceiver_direction_n <= 1'b1;
        end
        else
        begin
            smm_remap_enable        <= remap_w;
            smm_remap_hit           <= remap_w & seg_ab_w;
            dram_config_high        <= cfgh_w;
            dram_config_low         <= cfgl_w;
            parity_lane2_enable     <= one_q[dram_ctl_pkg::ONE_PAR_BIT];
            shared_pin_n            <= pin_w;
            read_timing             <= rd_prof_w;
            write_timing            <= wr_prof_w;
            cache_flush_out_n       <= ~flush_rise_w;                   // one clock
            transceiver_direction_n <= transceiver_request_n | transceiver_direction_n_mask_w;
        end
    end

    // ----------------------------------------
    // address strobe path
    // ----------------------------------------
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            strobe_d1_q      <= 1'b1;
            address_strobe_n <= 1'b1;
        end
        else
        begin
            strobe_d1_q      <= address_strobe_in_n;
            address_strobe_n <= strobe_late_w ? strobe_d1_q
                                              : address_strobe_in_n;
        end
    end

    // ----------------------------------------
    // isa bus clock
    // ----------------------------------------
    isa_clock_divider #(
        .CNT_W     (3)
    ) u_isa_div (
        .sys_clk   (sys_clk),
        .reset     (reset),
        .divisor   (divisor_w),
        .tick      (isa_clock_tick),
        .clk_level (isa_bus_clock)
    );

endmodule : dram_control_regs
`default_nettype wire

// >>> tb/dram_control_regs_sva.sv
// checker: port assertions for the dram control register pair
`timescale 1ns/1ps
`default_nettype none
module dram_control_regs_sva (
    input wire logic        sys_clk,
    input wire logic        reset,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    input wire logic [31:0] cpu_addr,
    input wire logic        smm_remap_enable,
    input wire logic        smm_remap_hit,
    input wire logic [5:0]  read_timing,
    input wire logic [5:0]  write_timing,
    input wire logic        write_burst_fast,
    input wire logic        cache_flush_out_n,
    input wire logic        transceiver_request_n,
    input wire logic        transceiver_direction_n,
    input wire logic        isa_clock_tick
);
    // ----------------------------------------
    // warm-up count keeps $past clear of reset
    // ----------------------------------------
    logic [1:0] live_q;  // cycles since release, saturating
    logic       up;      // past values are trustworthy
    assign up = live_q == 2'h3;
    // count up after reset release
    always_ff @(posedge sys_clk or posedge reset)
        if (reset)
            live_q <= 2'h0;
        else if (!up)
            live_q <= live_q + 2'h1;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    // bus request, answer and flush steps
    sequence req_s; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    sequence ack_s; wb_ack_o ##1 !wb_ack_o; endsequence
    sequence flush_s; !cache_flush_out_n ##1 cache_flush_out_n; endsequence
    bus_answer_a: assert property (req_s |=> ack_s)
        else $error("ack not one cycle after request");
    read_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("upper read data not zero");
    flush_width_a: assert property ($fell(cache_flush_out_n) |-> flush_s)
        else $error("flush pulse not one cycle");
    smm_hit_a: assert property (up && smm_remap_hit |-> smm_remap_enable
        && $past(cpu_addr[31:17]) == 15'h0005) else $error("remap hit outside segments");
    smm_miss_a: assert property (up && $past(cpu_addr[31:17]) != 15'h0005 |-> !smm_remap_hit)
        else $error("remap hit on wrong address");
    read_code_a: assert property (read_timing inside {6'h1A, 6'h23, 6'h2C})
        else $error("illegal read profile");
    write_fast_a: assert property (up && write_timing[5:3] == 3'h3 |->
        write_timing[2:0] == ($past(write_burst_fast) ? 3'h2 : 3'h3))
        else $error("write burst choice wrong");
    dir_pass_a: assert property (up && $past(transceiver_request_n) |-> transceiver_direction_n)
        else $error("direction strobe without request");
    tick_pulse_a: assert property (isa_clock_tick |=> !isa_clock_tick)
        else $error("isa tick longer than one cycle");
endmodule : dram_control_regs_sva
bind dram_control_regs dram_control_regs_sva chk (.sys_clk, .reset, .wb_cyc_i, .wb_stb_i,
    .wb_ack_o, .wb_dat_o, .cpu_addr, .smm_remap_enable, .smm_remap_hit, .read_timing,
    .write_timing, .write_burst_fast, .cache_flush_out_n, .transceiver_request_n,
    .transceiver_direction_n, .isa_clock_tick);
`default_nettype wire

// >>> tb/dram_control_register_pair_tb.sv
// testbench: random and corner tests of the dram control register pair
`timescale 1ns/1ps
`default_nettype none
module dram_control_register_pair_tb;
    logic        sys_clk, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, io_cycle;
    logic [7:0]  wb_adr_i, rd, v;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, cpu_addr;
    logic        pin_function_strap, cache_module_enable, write_burst_fast;
    logic        strobe_delay_enable, address_strobe_in_n, memory_data_direction_n;
    logic        local_memory_indicate_n, transceiver_request_n, smm_remap_enable;
    logic        smm_remap_hit, parity_lane2_enable, shared_pin_n, cache_flush_out_n;
    logic        transceiver_direction_n, address_strobe_n, isa_bus_clock, isa_clock_tick;
    logic [15:0] io_port;
    logic [2:0]  dram_config_high, dram_config_low;
    logic [5:0]  read_timing, write_timing;
    int          n_mismatch, samples_checked, seed, i, k, h, fl_cnt;
    dram_control_regs uut (.sys_clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pin_function_strap, .cache_module_enable,
        .write_burst_fast, .strobe_delay_enable, .cpu_addr, .io_cycle, .io_port,
        .address_strobe_in_n, .memory_data_direction_n, .local_memory_indicate_n,
        .transceiver_request_n, .smm_remap_enable, .smm_remap_hit, .dram_config_high,
        .dram_config_low, .parity_lane2_enable, .shared_pin_n, .read_timing, .write_timing,
        .cache_flush_out_n, .transceiver_direction_n, .address_strobe_n, .isa_bus_clock,
        .isa_clock_tick);
    // 200 mhz clock, flush low-cycle counter
    always #2.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (cache_flush_out_n === 1'b0) fl_cnt++;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : tick
    // classic wishbone cycle, held until ack is sampled
    task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d,
                      input logic [3:0] s = 4'hF);
        @(posedge sys_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, w};
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= {24'h0, d};
        @(posedge sys_clk);
        while (wb_ack_o !== 1'b1) @(posedge sys_clk);
        rd = wb_dat_o[7:0];
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
    endtask : wb
    // expected profiles
    function automatic logic [5:0] exp_rd(input logic [1:0] c);
        return (c == 2'h0) ? 6'h1A : (c == 2'h2) ? 6'h23 : 6'h2C;
    endfunction : exp_rd
    function automatic logic [5:0] exp_wr(input logic b, input logic f);
        return b ? 6'h23 : (f ? 6'h1A : 6'h1B);
    endfunction : exp_wr
    // write flush bit from a start value and count low cycles
    task automatic flush_try(input logic en, input logic [7:0] first, input int n);
        cache_module_enable <= en;
        wb(8'h94, 1'h1, first);
        fl_cnt = 0;
        wb(8'h94, 1'h1, 8'h08);
        tick(4);
        chk(fl_cnt, n);
    endtask : flush_try
    task print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict
    // watchdog against a hung handshake
    initial
    begin
        #60000;
        n_mismatch++;
        print_verdict;
    end
    initial
    begin
        {sys_clk, reset, wb_cyc_i, wb_stb_i, wb_we_i, io_cycle} = 6'h10;
        {wb_adr_i, wb_dat_i, cpu_addr, io_port, wb_sel_i} = {88'h0, 4'hF};
        {pin_function_strap, cache_module_enable, write_burst_fast} = 3'h0;
        {strobe_delay_enable, address_strobe_in_n, memory_data_direction_n} = 3'h3;
        {local_memory_indicate_n, transceiver_request_n} = 2'h3;
        {n_mismatch, samples_checked, seed} = {32'h0, 32'h0, 32'h2609};
        repeat (5) @(posedge sys_clk);
        reset <= 1'h0;
        tick(2);
        wb(8'h90, 1'h0, 8'h0); chk(rd, 8'h08);
        wb(8'h94, 1'h0, 8'h0); chk(rd, 8'h70);
        chk({read_timing, write_timing}, 12'hB23);
        chk({dram_config_high, parity_lane2_enable, dram_config_low}, 7'h08);
        for (i = 0; i < 24; i++)
        begin
            v = 8'($random(seed));
            write_burst_fast <= v[3];
            wb(8'h90, 1'h1, v); wb(8'h90, 1'h0, 8'h0); chk(rd, v);
            tick(2);
            chk({smm_remap_enable, dram_config_high, parity_lane2_enable, dram_config_low}, v);
            v = 8'($random(seed));
            wb(8'h94, 1'h1, v); wb(8'h94, 1'h0, 8'h0); chk(rd, v);
            tick(2);
            chk(read_timing, exp_rd(v[6:5]));
            chk(write_timing, exp_wr(v[4], write_burst_fast));
        end
        // unmapped address, then a write with no byte lane
        wb(8'h98, 1'h1, 8'hFF); wb(8'h98, 1'h0, 8'h0); chk(rd, 8'h0);
        wb(8'h90, 1'h1, 8'h3C);
        wb(8'h90, 1'h1, 8'h55, 4'h0);
        wb(8'h90, 1'h0, 8'h0); chk(rd, 8'h3C);
        flush_try(1'h1, 8'h00, 1);
        flush_try(1'h1, 8'h08, 0);
        flush_try(1'h0, 8'h00, 0);
        flush_try(1'h1, 8'h00, 1);
        // isa clock period per code
        for (i = 0; i < 4; i++)
        begin
            wb(8'h94, 1'h1, 8'(i));
            tick(8);
            @(posedge sys_clk iff isa_clock_tick === 1'b1);
            k = 0;
            h = 0;
            do begin @(posedge sys_clk); k++; h += int'(isa_bus_clock); end
            while (isa_clock_tick !== 1'b1 && k < 9);
            chk(k, 6 - i);
            chk(h > 0 && h < k, 1'h1);
        end
        // strobe delay: code 00 without and with delay, then code 01
        for (i = 0; i < 3; i++)
        begin
            strobe_delay_enable <= i != 0;
            wb(8'h94, 1'h1, 8'(i == 2));
            tick(2);
            address_strobe_in_n <= 1'h0;
            @(posedge sys_clk);
            address_strobe_in_n <= 1'h1;
            k = 1;
            do begin @(posedge sys_clk); k++; end while (address_strobe_n !== 1'b0 && k < 6);
            chk(k, 2 + (i == 1));
        end
        // direction strobe suppression over ports
        wb(8'h94, 1'h1, 8'h04);
        {io_cycle, transceiver_request_n} <= 2'h2;
        for (i = 0; i < 5; i++)
        begin
            io_port <= (i == 4) ? 16'h0061 : (i < 2) ? 16'h0060 + 16'(4 * i) : 16'h006E + 16'(i);
            tick(3);
            chk(transceiver_direction_n, i < 4);
        end
        wb(8'h94, 1'h1, 8'h00); io_port <= 16'h0070; tick(3);
        chk(transceiver_direction_n, 1'h0);
        // remap hits in both segments only
        wb(8'h90, 1'h1, 8'h80);
        for (i = 0; i < 4; i++)
        begin
            cpu_addr <= (i == 0) ? 32'hA0000 : (i == 1) ? 32'hBFFFF : (i == 2) ? 32'hC0000 : 32'h9FFFF;
            tick(3);
            chk(smm_remap_hit, i < 2);
        end
        wb(8'h90, 1'h1, 8'h00); cpu_addr <= 32'hA0000; tick(3); chk(smm_remap_hit, 1'h0);
        // shared pin follows the select bit with strap low
        {memory_data_direction_n, local_memory_indicate_n} <= 2'h2;
        wb(8'h94, 1'h1, 8'h80); tick(3); chk(shared_pin_n, 1'h0);
        wb(8'h94, 1'h1, 8'h00); tick(3); chk(shared_pin_n, 1'h1);
        // mid-run reset with strap high: defaults back, select bit inert
        {reset, pin_function_strap} <= 2'h3;
        tick(2);
        reset <= 1'h0;
        tick(2);
        wb(8'h90, 1'h0, 8'h0); chk(rd, 8'h08);
        wb(8'h94, 1'h1, 8'h80); tick(3); chk(shared_pin_n, 1'h1);
        print_verdict;
    end
endmodule : dram_control_register_pair_tb
`default_nettype wire
